//--- logic/mac_tx_interpacket_gap.sv
/*
   Transmit interpacket gap timer with its APB register file.
   Assumes i_tx_end pulses for one cycle when a packet's last nibble leaves,
   i_nibble_tick pulses once per nibble time, both on i_ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module mac_tx_interpacket_gap
(
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic i_nibble_tick,
   input wire logic i_tx_req,
   input wire logic i_tx_end,
   output logic o_tx_allow,
   output logic o_gap_active
);
   typedef struct packed {
      logic [6:0] gap_value_field;
      logic full_duplex;
      logic gap_active;
      logic [7:0] count;
      logic [31:0] rdata;
      logic slverr;
      logic ready;
   } state_s;

   state_s r;
   state_s next_r;
   logic [7:0] target;
   logic acc;
   logic half_ok;
   logic [6:0] wv;
   logic [31:0] rd;

   assign target = {1'b0, r.gap_value_field} + (r.full_duplex ? ipg_pkg::FULL_OFFSET
                                                               : ipg_pkg::HALF_OFFSET);
   assign acc = psel && penable;
   assign half_ok = (pstrb == 4'h3) || (pstrb == 4'hC) || (pstrb == 4'hF);
   // only the low byte lane holds the field
   assign wv = pwdata[6:0] & {7{pstrb[0]}};

   always_comb
   begin
      next_r = r;
      rd = 32'h0000_0000;
      unique case (paddr)
         ipg_pkg::ADDR_GAP, ipg_pkg::ADDR_GAP_CLR, ipg_pkg::ADDR_GAP_SET, ipg_pkg::ADDR_GAP_INV:
            rd = {25'h0, r.gap_value_field};
         ipg_pkg::ADDR_CTRL:
            rd = {31'h0, r.full_duplex};
         ipg_pkg::ADDR_STATUS:
            rd = {30'h0, r.gap_active, !o_tx_allow};
         default:
            rd = 32'h0000_0000;
      endcase
      // One wait state: the first access edge loads read data, the second answers
      next_r.ready = acc && !r.ready;
      if (acc && !r.ready)
      begin
         next_r.rdata = rd;
         next_r.slverr = (paddr > ipg_pkg::ADDR_STATUS || paddr[1:0] != 2'b00)
                         && (!pwrite || half_ok);
      end
      else if (acc)
      begin
         if (pwrite)
         begin
            if (half_ok)
            begin
               unique case (paddr)
                  ipg_pkg::ADDR_GAP:
                     next_r.gap_value_field = (r.gap_value_field & ~{7{pstrb[0]}}) | wv;
                  ipg_pkg::ADDR_GAP_CLR:
                     next_r.gap_value_field = r.gap_value_field & ~wv;
                  ipg_pkg::ADDR_GAP_SET:
                     next_r.gap_value_field = r.gap_value_field | wv;
                  ipg_pkg::ADDR_GAP_INV:
                     next_r.gap_value_field = r.gap_value_field ^ wv;
                  ipg_pkg::ADDR_CTRL:
                     if (pstrb[0])
                     begin
                        next_r.full_duplex = pwdata[ipg_pkg::CTRL_FULL_BIT];
                     end
                  default:
                     next_r.slverr = r.slverr;
               endcase
            end
         end
      end
      // restart the gap count at each packet end
      if (i_tx_end)
      begin
         next_r.gap_active = 1'b1;
         next_r.count = 8'h00;
      end
      else if (r.gap_active && i_nibble_tick)
      begin
         if (r.count + 8'h01 >= target)
         begin
            next_r.gap_active = 1'b0;
         end
         next_r.count = r.count + 8'h01;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         r <= '{gap_value_field: ipg_pkg::GAP_RESET, full_duplex: 1'b0, gap_active: 1'b0,
                count: 8'h00, rdata: 32'h0000_0000, slverr: 1'b0, ready: 1'b0};
      end
      else if (i_ce)
      begin
         r <= next_r;
      end
   end

   assign prdata = r.rdata;
   // Answer one cycle into the access phase so read data comes from a flop
   assign pready = r.ready;
   assign pslverr = r.slverr & r.ready & acc;
   // new packet held until the gap has elapsed
   assign o_tx_allow = i_tx_req && !r.gap_active && !i_tx_end;
   assign o_gap_active = r.gap_active;
endmodule
`default_nettype wire

//--- logic/ipg_pkg.sv
/*
   Constants for the transmit interpacket gap block: register map, field
   layout, reset values and duplex offsets.
   Assumes an APB slave with 32-bit data; one aligned word per register.
*/
// Functional notes
// - Seven-bit gap field sets minimum spacing
// - Full duplex gap is value plus three
// - Half duplex gap is value plus six
// - Bits 31 to 7 read zero, ignore writes
// - Byte accesses ignored; halfword and word accepted
package ipg_pkg;
   localparam int GAP_W = 7;
   // Base plus set, clear and invert aliases
   localparam logic [11:0] ADDR_GAP = 12'h000;
   localparam logic [11:0] ADDR_GAP_CLR = 12'h004;
   localparam logic [11:0] ADDR_GAP_SET = 12'h008;
   localparam logic [11:0] ADDR_GAP_INV = 12'h00C;
   localparam logic [11:0] ADDR_CTRL = 12'h010;
   localparam logic [11:0] ADDR_STATUS = 12'h014;
   localparam logic [6:0] GAP_RESET = 7'h12;
   localparam logic [7:0] FULL_OFFSET = 8'h03;
   localparam logic [7:0] HALF_OFFSET = 8'h06;
   localparam int CTRL_FULL_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_GAP_BIT = 1;
endpackage

//--- tb/ipg_checker.sv
/* Port assertions for the gap block; bound into every instance. */
`timescale 1ns/10ps
`default_nettype none
module ipg_checker
(
   input wire logic i_ref_clk, i_rstn, i_ce, psel, penable, pslverr,
   input wire logic i_nibble_tick, i_tx_end, o_tx_allow, o_gap_active,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   a_gap_start: assert property (i_ce && i_tx_end |=> o_gap_active)
      else $error("gap not started");
   a_allow_block: assert property (o_gap_active |-> !o_tx_allow)
      else $error("allowed in gap");
   a_gap_fall: assert property ($fell(o_gap_active) |-> $past(i_nibble_tick))
      else $error("gap end off tick");
   a_upper_zero: assert property (prdata[31:7] == 25'h0)
      else $error("upper bits set");
   a_mapped_ok: assert property (psel && penable && paddr == 12'h000 |-> !pslverr)
      else $error("gap reg error");
   a_hold_frozen: assert property (!i_ce |=> $stable(o_gap_active))
      else $error("moved while frozen");
   c_gap_end: cover property ($fell(o_gap_active));
   c_err: cover property (psel && penable && pslverr);
   c_allow: cover property (o_tx_allow);
endmodule
bind mac_tx_interpacket_gap ipg_checker i_chk (.*);
`default_nettype wire

//--- tb/phy_model.sv
/* PHY stand-in: nibble tick every other cycle, four-nibble packets. */
`timescale 1ns/10ps
`default_nettype none
module phy_model
(
   input wire logic i_clk, i_rstn, i_allow,
   output logic o_tick, o_tx_end
);
   logic [2:0] n;
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         {o_tick, o_tx_end, n} <= 5'h00;
      else
      begin
         o_tick <= !o_tick;
         o_tx_end <= o_tick && n == 3'h4;
         if (o_tx_end)
            n <= 3'h0;
         else if (o_tick && n != 3'h4 && (i_allow || n != 3'h0))
            n <= n + 3'h1;
      end
   end
endmodule
`default_nettype wire

//--- tb/mac_tx_interpacket_gap_tb.sv
/* Gap block bench; checker and PHY stand-in come from their own files. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] %0t bad", $time); end end
module mac_tx_interpacket_gap_tb;
   logic i_ref_clk = 0, i_rstn = 0, psel = 0, penable = 0, pwrite = 0, req = 0, ce = 1;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = '0;
   logic pready, pslverr, err, tick, tx_end, allow, gap;
   int n_fail = 0, checked = 0, ticks = 0;
   always #10 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) ticks <= tx_end ? 0 : ticks + (gap && tick && ce);
   mac_tx_interpacket_gap i_dut (.i_ref_clk, .i_rstn, .i_ce(ce), .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .i_nibble_tick(tick),
      .i_tx_req(req), .i_tx_end(tx_end), .o_tx_allow(allow), .o_gap_active(gap));
   phy_model i_phy (.i_clk(i_ref_clk), .i_rstn, .i_allow(allow), .o_tick(tick), .o_tx_end(tx_end));
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
      @(posedge i_ref_clk) penable <= 1'b1;
      do @(posedge i_ref_clk); while (pready !== 1'b1);
      err = pslverr;
      rd = prdata;
      {psel, penable} <= 2'h0;
      @(posedge i_ref_clk);
   endtask
   task t_regs;
      apb(0, 12'h000, '0, 4'hF);
      `CHK(rd, 32'h12)
      apb(1, 12'h000, 32'hFFFFFF85, 4'hF);
      apb(0, 12'h000, '0, 4'hF);
      `CHK(rd, 32'h05)
      apb(1, 12'h000, 32'h0A, 4'h1);
      apb(1, ipg_pkg::ADDR_GAP_INV, 32'h0F, 4'h3);
      apb(0, 12'h000, '0, 4'h3);
      `CHK(rd, 32'h0A)
      apb(0, 12'h020, '0, 4'hF);
      `CHK(err, 1'b1)
      $display("t_regs done");
   endtask
   task t_gap(input logic f, input logic [6:0] v, input int n);
      apb(1, ipg_pkg::ADDR_CTRL, {31'h0, f}, 4'hF);
      apb(1, 12'h000, {25'h0, v}, 4'hF);
      req <= 1'b1;
      wait (gap === 1'b1);
      @(posedge i_ref_clk) req <= 1'b0;
      ce <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      `CHK(gap, 1'b1)
      ce <= 1'b1;
      wait (gap === 1'b0);
      @(posedge i_ref_clk);
      `CHK(ticks, n)
      $display("t_gap done");
   endtask
   task summarize;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      @(posedge i_ref_clk);
      t_regs;
      t_gap(1'b1, 7'h15, 24);
      t_gap(1'b0, 7'h12, 24);
      t_gap(1'b0, 7'h00, 6);
      summarize;
   end
   initial
   begin
      #100000;
      n_fail++;
      summarize;
   end
endmodule
`default_nettype wire
